// *** rtl/lcb_consts.vh ***
// constants of the logical and conditional branch execute slice
`ifndef LCB_CONSTS_VH
`define LCB_CONSTS_VH
// major opcodes, instruction bits 0..5 (bit 0 is the msb)
`define LCB_OP_ANDI 6'h29
`define LCB_OP_AND_COMPLEMENT_REG_OP 6'h23
`define LCB_OP_ANDNI 6'h2B
`define LCB_OP_BCC_REG 6'h27
`define LCB_OP_BCC_IMM 6'h2F
// condition codes, instruction bits 7..10
`define LCB_CC_EQ 4'h0
`define LCB_CC_NE 4'h1
`define LCB_CC_LT 4'h2
`define LCB_CC_LE 4'h3
`define LCB_CC_GT 4'h4
`define LCB_CC_GE 4'h5
// field positions, lsb numbering
`define LCB_OPC_HI 31
`define LCB_OPC_LO 26
`define LCB_RD_HI 25
`define LCB_RD_LO 21
`define LCB_RA_HI 20
`define LCB_RA_LO 16
`define LCB_RB_HI 15
`define LCB_RB_LO 11
`define LCB_DBIT 25
`define LCB_CC_HI 24
`define LCB_CC_LO 21
`define LCB_IMM_HI 15
`define LCB_IMM_LO 0
// execution latencies in cycles
`define LCB_LAT_LOGIC 2'h1
`define LCB_LAT_NOT_TAKEN 2'h1
`define LCB_LAT_TAKEN_DELAY 2'h2
`define LCB_LAT_TAKEN_NODELAY 2'h3
// pc reset value and pc step
`define LCB_PC_RESET 32'h00000000
`define LCB_PC_STEP 32'h00000004
`endif

// *** rtl/lcb_regfile.v ***
// register file holding the general purpose registers, registered read ports
`timescale 1ns/1ps
module lcb_regfile #(
   parameter DATA_W = 32,
   parameter ADDR_W = 5
) (
   input wire sys_clk_in,
   input wire wr_en_in,
   input wire [ADDR_W-1:0] wr_addr_in,
   input wire [DATA_W-1:0] wr_data_in,
   input wire [ADDR_W-1:0] rd_a_addr_in,
   input wire [ADDR_W-1:0] rd_b_addr_in,
   output reg [DATA_W-1:0] rd_a_data_out,
   output reg [DATA_W-1:0] rd_b_data_out
);
   reg [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];
   integer i;

   // register zero reads as zero always
   initial begin
      for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
         mem_r[i] = {DATA_W{1'b0}};
      end
   end

   // write port, writes to register zero dropped
   always @(posedge sys_clk_in) begin
      if (wr_en_in && (wr_addr_in != {ADDR_W{1'b0}})) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
   end

   // read ports, data out of a register
   always @(posedge sys_clk_in) begin
      rd_a_data_out <= mem_r[rd_a_addr_in];
      rd_b_data_out <= mem_r[rd_b_addr_in];
   end
endmodule // lcb_regfile

// *** rtl/lcb_exec.v ***
// decode and execute of and-immediate, and-not forms and conditional branches
//
// What this block does
// - and-immediate: first source AND sign-extended 16-bit immediate into destination.
// - and-not: first source AND complement of second source into destination.
// - and-not-immediate: first source AND complement of sign-extended immediate.
// - branch-equal register form: pc plus second source if first is zero, else plus 4.
// - immediate branch forms: target is pc plus sign-extended 16-bit immediate.
// - greater-or-equal branches taken only when first source is at least zero.
// - greater-than branches taken only when first source is above zero.
// - less-or-equal branches taken only when first source is at most zero.
// - delay bit set: following instruction completes before the target.
// - delay bit clear: following instruction squashed, target executes next.
// - delay control is instruction bit 6, set by the with-delay variants.
// - a not-taken conditional branch takes one cycle.
// - a taken branch with delay bit set takes two cycles.
// - a taken branch with delay bit clear takes three cycles.
`timescale 1ns/1ps
`include "lcb_consts.vh"
module lcb_exec #(
   parameter DATA_W = 32,
   parameter ADDR_W = 5
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire instr_valid_in,
   input wire [31:0] instr_in,
   output reg instr_ready_out,
   output reg [31:0] pc_out,
   output reg done_out,
   output reg branch_taken_out,
   output reg squash_out,
   output reg illegal_out,
   output reg wr_en_out,
   output reg [ADDR_W-1:0] wr_addr_out,
   output reg [DATA_W-1:0] wr_data_out
);
   // ****************************************************************
   // decode and state
   // ****************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_EXEC = 2'h2;
   localparam ST_WAIT = 2'h3;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [31:0] instr_r;
   reg [1:0] wait_r;
   reg [1:0] wait_nxt;
   reg squash_pend_r;
   reg squash_pend_nxt;
   wire [DATA_W-1:0] first_source_register;
   wire [DATA_W-1:0] second_source_register;
   wire [5:0] opc;
   wire [3:0] cc;
   wire delay_bit;
   wire [DATA_W-1:0] imm_ext;
   wire cond_true;

   // sign-extend a 16-bit immediate
   function [DATA_W-1:0] sext16;
      input [15:0] v;
      begin
         sext16 = {{(DATA_W-16){v[15]}}, v};
      end
   endfunction

   // signed comparison against zero by condition code
   function cond_eval;
      input [3:0] code;
      input [DATA_W-1:0] v;
      reg neg;
      reg zero;
      begin
         neg = v[DATA_W-1];
         zero = (v == {DATA_W{1'b0}});
         case (code)
            `LCB_CC_EQ: cond_eval = zero;
            `LCB_CC_NE: cond_eval = !zero;
            `LCB_CC_LT: cond_eval = neg;
            `LCB_CC_LE: cond_eval = neg || zero;
            `LCB_CC_GT: cond_eval = !neg && !zero;
            `LCB_CC_GE: cond_eval = !neg;
            default: cond_eval = 1'b0;
         endcase
      end
   endfunction

   assign opc = instr_r[`LCB_OPC_HI:`LCB_OPC_LO];
   assign cc = instr_r[`LCB_CC_HI:`LCB_CC_LO];
   assign delay_bit = instr_r[`LCB_DBIT];
   assign imm_ext = sext16(instr_r[`LCB_IMM_HI:`LCB_IMM_LO]);
   assign cond_true = cond_eval(cc, first_source_register);

   // ****************************************************************
   // register file
   // ****************************************************************
   lcb_regfile #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W)
   ) u_regfile (
      .sys_clk_in(sys_clk_in),
      .wr_en_in(wr_en_out),
      .wr_addr_in(wr_addr_out),
      .wr_data_in(wr_data_out),
      .rd_a_addr_in(instr_r[`LCB_RA_HI:`LCB_RA_LO]),
      .rd_b_addr_in(instr_r[`LCB_RB_HI:`LCB_RB_LO]),
      .rd_a_data_out(first_source_register),
      .rd_b_data_out(second_source_register)
   );

   // ****************************************************************
   // sequencing
   // ****************************************************************
   // next state: idle takes, read fetches operands, exec acts, wait burns cycles
   always @* begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      squash_pend_nxt = squash_pend_r;
      case (state_r)
         ST_IDLE: begin
            if (instr_valid_in) begin
               state_nxt = ST_READ;
            end
         end
         ST_READ: begin
            state_nxt = ST_EXEC;
         end
         ST_EXEC: begin
            state_nxt = ST_IDLE;
            if (((opc == `LCB_OP_BCC_REG) || (opc == `LCB_OP_BCC_IMM)) && cond_true) begin
               if (delay_bit) begin
                  wait_nxt = `LCB_LAT_TAKEN_DELAY - 2'h1;
               end else begin
                  wait_nxt = `LCB_LAT_TAKEN_NODELAY - 2'h1;
                  squash_pend_nxt = 1'b1;
               end
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            wait_nxt = wait_r - 2'h1;
            if (wait_r == 2'h1) begin
               state_nxt = ST_IDLE;
               squash_pend_nxt = 1'b0;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // state registers and outputs
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_r <= ST_IDLE;
         wait_r <= 2'h0;
         squash_pend_r <= 1'b0;
         instr_r <= 32'h00000000;
         instr_ready_out <= 1'b1;
         pc_out <= `LCB_PC_RESET;
         done_out <= 1'b0;
         branch_taken_out <= 1'b0;
         squash_out <= 1'b0;
         illegal_out <= 1'b0;
         wr_en_out <= 1'b0;
         wr_addr_out <= {ADDR_W{1'b0}};
         wr_data_out <= {DATA_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
         squash_pend_r <= squash_pend_nxt;
         done_out <= 1'b0;
         branch_taken_out <= 1'b0;
         squash_out <= 1'b0;
         illegal_out <= 1'b0;
         wr_en_out <= 1'b0;
         instr_ready_out <= (state_nxt == ST_IDLE);
         // take an instruction
         if ((state_r == ST_IDLE) && instr_valid_in) begin
            instr_r <= instr_in;
         end
         // execute with operands now read
         if (state_r == ST_EXEC) begin
            case (opc)
               `LCB_OP_ANDI: begin
                  wr_en_out <= 1'b1;
                  wr_addr_out <= instr_r[`LCB_RD_HI:`LCB_RD_LO];
                  wr_data_out <= first_source_register & imm_ext;
                  pc_out <= pc_out + `LCB_PC_STEP;
                  done_out <= 1'b1;
               end
               `LCB_OP_AND_COMPLEMENT_REG_OP: begin
                  wr_en_out <= 1'b1;
                  wr_addr_out <= instr_r[`LCB_RD_HI:`LCB_RD_LO];
                  wr_data_out <= first_source_register & ~second_source_register;
                  pc_out <= pc_out + `LCB_PC_STEP;
                  done_out <= 1'b1;
               end
               `LCB_OP_ANDNI: begin
                  wr_en_out <= 1'b1;
                  wr_addr_out <= instr_r[`LCB_RD_HI:`LCB_RD_LO];
                  wr_data_out <= first_source_register & ~imm_ext;
                  pc_out <= pc_out + `LCB_PC_STEP;
                  done_out <= 1'b1;
               end
               `LCB_OP_BCC_REG, `LCB_OP_BCC_IMM: begin
                  if (cond_true) begin
                     branch_taken_out <= 1'b1;
                     if (opc == `LCB_OP_BCC_REG) begin
                        pc_out <= pc_out + second_source_register;
                     end else begin
                        pc_out <= pc_out + imm_ext;
                     end
                  end else begin
                     pc_out <= pc_out + `LCB_PC_STEP;
                     done_out <= 1'b1;
                  end
               end
               default: begin
                  illegal_out <= 1'b1;
                  pc_out <= pc_out + `LCB_PC_STEP;
                  done_out <= 1'b1;
               end
            endcase
         end
         // end of a taken branch; slot instruction kept when delay bit set
         if ((state_r == ST_WAIT) && (wait_r == 2'h1)) begin
            done_out <= 1'b1;
            squash_out <= squash_pend_r;
         end
      end
   end
endmodule // lcb_exec

// *** tb/lcb_exec_asserts.sv ***
// port assertions for the logic and branch execute slice
`timescale 1ns/1ps
`include "lcb_consts.vh"
module lcb_exec_asserts (
   input wire sys_clk_in,
   input wire rst_in,
   input wire instr_valid_in,
   input wire [31:0] instr_in,
   input wire instr_ready_out,
   input wire [31:0] pc_out,
   input wire done_out,
   input wire branch_taken_out,
   input wire squash_out,
   input wire illegal_out,
   input wire wr_en_out,
   input wire [4:0] wr_addr_out,
   input wire [31:0] wr_data_out
);
   // ****
   // word under execution and its decode
   // ****
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   reg [31:0] cur_r;
   wire take = instr_valid_in && instr_ready_out;
   wire [5:0] op = instr_in[31:26];
   wire is_br = (op == `LCB_OP_BCC_REG) || (op == `LCB_OP_BCC_IMM);
   wire is_log = (op == `LCB_OP_ANDI) || (op == `LCB_OP_AND_COMPLEMENT_REG_OP) || (op == `LCB_OP_ANDNI);
   // capture the word on the taking edge
   always @(posedge sys_clk_in) begin
      if (take) begin
         cur_r <= instr_in;
      end
   end
   a_ready_falls: assert property (take |=> !instr_ready_out) else $error("ready high after take");
   a_logic_write: assert property (take && is_log |-> ##3 wr_en_out && done_out)
      else $error("logic op write late");
   a_write_dest: assert property (wr_en_out |-> wr_addr_out == cur_r[25:21])
      else $error("wrong destination");
   a_branch_exec: assert property (take && is_br |-> ##3 (branch_taken_out || done_out) && !wr_en_out)
      else $error("branch exec cycle wrong");
   a_pc_step: assert property (take && is_br |-> ##3 (branch_taken_out || pc_out == $past(pc_out) + 32'h4))
      else $error("pc step wrong");
   a_imm_target: assert property (branch_taken_out && cur_r[31:26] == `LCB_OP_BCC_IMM |->
      pc_out == $past(pc_out) + {{16{cur_r[15]}}, cur_r[15:0]}) else $error("imm target wrong");
   a_delay_done: assert property (branch_taken_out && cur_r[25] |=> done_out && !squash_out)
      else $error("delay branch done wrong");
   a_nodelay_done: assert property (branch_taken_out && !cur_r[25] |=> !done_out ##1 done_out && squash_out)
      else $error("plain branch done wrong");
   a_squash_cause: assert property (squash_out |-> done_out && $past(branch_taken_out, 2) && !cur_r[25])
      else $error("squash without cause");
   a_illegal_done: assert property (illegal_out |-> done_out && !wr_en_out && !branch_taken_out)
      else $error("illegal op acted");
endmodule // lcb_exec_asserts

bind lcb_exec lcb_exec_asserts lcb_exec_asserts_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out), .pc_out(pc_out),
   .done_out(done_out), .branch_taken_out(branch_taken_out), .squash_out(squash_out), .illegal_out(illegal_out),
   .wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out));

// *** tb/lcb_fetch_model.sv ***
// instruction fetch model offering one word at a time
`timescale 1ns/1ps
module lcb_fetch_model (
   input wire logic sys_clk_in,
   input wire logic instr_ready_in,
   output logic instr_valid_out,
   output logic [31:0] instr_out
);
   // ****
   // offer and release
   // ****
   logic sent = 1'b0;
   initial instr_valid_out = 1'b0;
   initial instr_out = 32'h0;
   // offer a word, hold it until the edge that takes it
   task automatic issue(input logic [31:0] w);
      @(negedge sys_clk_in);
      instr_valid_out = 1'b1;
      instr_out = w;
      while (instr_ready_in !== 1'b1) @(negedge sys_clk_in);
      @(posedge sys_clk_in);
      sent = 1'b1;
   endtask
   // release after the take; inverted word so stale data never matches
   always @(negedge sys_clk_in) begin
      if (sent) begin
         instr_valid_out <= 1'b0;
         instr_out <= ~instr_out;
         sent <= 1'b0;
      end
   end
endmodule // lcb_fetch_model

// *** tb/lcb_exec_bench.sv ***
// self-checking bench for the logic and branch execute slice
`timescale 1ns/1ps
`include "lcb_consts.vh"
module lcb_exec_bench;
   // ****
   // design, fetch model, reference model
   // ****
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic instr_valid_in, instr_ready_out, done_out, branch_taken_out, squash_out, illegal_out, wr_en_out;
   logic [31:0] instr_in, pc_out, wr_data_out;
   logic [4:0] wr_addr_out;
   logic [31:0] rf [32];
   logic [31:0] pc_m = 32'h0;
   logic [15:0] lfsr = 16'h4142;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   lcb_exec lcb_exec_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .instr_ready_out(instr_ready_out), .pc_out(pc_out), .done_out(done_out),
      .branch_taken_out(branch_taken_out), .squash_out(squash_out), .illegal_out(illegal_out),
      .wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out));
   lcb_fetch_model lcb_fetch_model_i (.sys_clk_in(sys_clk_in), .instr_ready_in(instr_ready_out),
      .instr_valid_out(instr_valid_in), .instr_out(instr_in));
   // clock and cycle ceiling
   initial forever #5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         complete_run();
      end
   end
   function automatic logic [15:0] step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one instruction through design and model, results compared at done
   task automatic run(input logic [31:0] w);
      logic [31:0] a, b, s, res;
      logic br, tk, ill;
      int k, kb, kd, kw;
      a = rf[w[20:16]];
      b = rf[w[15:11]];
      s = {{16{w[15]}}, w[15:0]};
      br = (w[31:26] == `LCB_OP_BCC_REG) || (w[31:26] == `LCB_OP_BCC_IMM);
      ill = !br && (w[31:26] != `LCB_OP_ANDI) && (w[31:26] != `LCB_OP_AND_COMPLEMENT_REG_OP) && (w[31:26] != `LCB_OP_ANDNI);
      case (w[24:21])
         `LCB_CC_EQ: tk = a == 0;
         `LCB_CC_NE: tk = a != 0;
         `LCB_CC_LT: tk = $signed(a) < 0;
         `LCB_CC_LE: tk = $signed(a) <= 0;
         `LCB_CC_GT: tk = $signed(a) > 0;
         default: tk = $signed(a) >= 0;
      endcase
      tk = tk && br;
      case (w[31:26])
         `LCB_OP_ANDI: res = a & s;
         `LCB_OP_AND_COMPLEMENT_REG_OP: res = a & ~b;
         default: res = a & ~s;
      endcase
      lcb_fetch_model_i.issue(w);
      kb = -1;
      kw = -1;
      kd = -1;
      for (k = 0; k < 8 && kd < 0; k++) begin
         @(negedge sys_clk_in);
         if (branch_taken_out === 1'b1) kb = k;
         if (wr_en_out === 1'b1) kw = k;
         if (done_out === 1'b1) kd = k;
      end
      chk("done_cycle", tk ? (w[25] ? 3 : 4) : 2, kd);
      chk("taken_cycle", tk ? 2 : -1, kb);
      chk("write_cycle", (br || ill) ? -1 : 2, kw);
      chk("squash", tk && !w[25], squash_out);
      chk("illegal", ill, illegal_out);
      pc_m = tk ? pc_m + ((w[31:26] == `LCB_OP_BCC_IMM) ? s : b) : pc_m + 32'h4;
      chk("pc", pc_m, pc_out);
      if (!br && !ill) begin
         chk("wr_addr", w[25:21], wr_addr_out);
         chk("wr_data", res, wr_data_out);
         if (w[25:21] != 0) rf[w[25:21]] = res;
      end
   endtask
   // reset, then every op, condition and delay choice in turn
   initial begin
      logic [31:0] w;
      int i;
      foreach (rf[j]) rf[j] = 32'h0;
      repeat (16) @(negedge sys_clk_in);
      // preload both register files; every fourth register stays zero
      for (i = 1; i < 32; i++) begin
         lfsr = step(lfsr);
         rf[i] = (i % 4 == 0) ? 32'h0 : {lfsr, step(lfsr)};
         lcb_exec_i.u_regfile.mem_r[i] = rf[i];
      end
      rst_in = 1'b0;
      for (i = 0; i < 74; i++) begin
         lfsr = step(lfsr);
         w[31:16] = lfsr;
         lfsr = step(lfsr);
         w[15:0] = lfsr;
         case (i % 3)
            0: w[31:26] = (i % 9 < 3) ? `LCB_OP_ANDI : (i % 9 < 6) ? `LCB_OP_AND_COMPLEMENT_REG_OP : `LCB_OP_ANDNI;
            1: w[31:26] = `LCB_OP_BCC_REG;
            default: w[31:26] = `LCB_OP_BCC_IMM;
         endcase
         if (i % 3 != 0) begin
            w[25] = ((i / 3) % 2) != 0;
            w[24:21] = 4'((i / 6) % 6);
         end
         // last two words carry opcodes outside the slice
         if (i >= 72) w[31:26] = (i == 72) ? 6'h00 : 6'h3F;
         if (w[31:26] == `LCB_OP_AND_COMPLEMENT_REG_OP || w[31:26] == `LCB_OP_BCC_REG) w[10:0] = 11'h000;
         run(w);
         $display("test %0d done", i);
      end
      complete_run();
   end
endmodule // lcb_exec_bench
